/* File: rfsirq_top.sv */
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - undervoltage indication for every converter and regulator
// - current monitoring only on converters 1, 2
// - converter overvoltage status at bits 13, 12
// - converter 2 high-current status at bit 9
// - converter 1 high-current status at bit 8
// - converter undervoltage status at bits 3:0
// - always-on regulator undervoltage at bit 15
// - regulator undervoltage status at bits 9:0
// - undervoltage flags set on rising edge
// - high-current flags set on rising edge
// - flags cleared only by writing one
// - unmasked undervoltage flags OR into primary irq
// - unmasked high-current flags raise primary irq
// - mask bit per flag, one blocks it
// - all mask bits reset to one
// - programmable current thresholds for converters 1, 2 only
// - current monitor reports only, never limits
module rfsirq_top
  import rfsirq_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // register port
  input wire logic [rfsirq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rfsirq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [rfsirq_pkg::DATA_W-1:0] o_rdata,
  // analog monitor comparators
  input wire rfsirq_pkg::rfsirq_mon_s i_mon,
  // thresholds to the current comparators
  output logic [rfsirq_pkg::THR_W-1:0] o_conv1_current_threshold,
  output logic [rfsirq_pkg::THR_W-1:0] o_conv2_current_threshold,
  // primary interrupts
  output logic o_primary_undervolt_irq,
  output logic o_primary_overcurrent_irq
);

  // live converter status word
  function automatic logic [DATA_W-1:0] conv_word(input rfsirq_mon_s m);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    w[CONV2_OV_BIT] = m.conv2_overvolt;
    w[CONV1_OV_BIT] = m.conv1_overvolt;
    w[CONV2_OC_BIT] = m.conv2_overcurrent;
    w[CONV1_OC_BIT] = m.conv1_overcurrent;
    w[CONV_UV_LSB +: NUM_CONV] = m.conv_undervolt;
    return w;
  endfunction

  // live regulator status word
  function automatic logic [DATA_W-1:0] reg_word(input rfsirq_mon_s m);
    logic [DATA_W-1:0] w;
    w = ZERO_WORD;
    w[ALWAYS_ON_UV_BIT] = m.always_on_undervolt;
    w[REG_UV_LSB +: NUM_REG] = m.regulator_undervolt;
    return w;
  endfunction

  // set wins over a same-cycle write-one clear
  function automatic logic [DATA_W-1:0] flag_next(
    input logic [DATA_W-1:0] flags,
    input logic hit,
    input logic [DATA_W-1:0] wdata,
    input logic [DATA_W-1:0] rise,
    input logic [DATA_W-1:0] impl
  );
    logic [DATA_W-1:0] clr;
    clr = hit ? wdata : ZERO_WORD;
    return ((flags & ~clr) | rise) & impl;
  endfunction

  // monitor synchroniser and edge history
  rfsirq_mon_s mon_meta_q, mon_meta_d;
  rfsirq_mon_s mon_sync_q, mon_sync_d;
  rfsirq_mon_s mon_prev_q, mon_prev_d;

  always_comb begin
    mon_meta_d = i_mon;
    mon_sync_d = mon_meta_q;
    mon_prev_d = mon_sync_q;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon_meta_q <= MON_RST;
      mon_sync_q <= MON_RST;
      mon_prev_q <= MON_RST;
    end else begin
      mon_meta_q <= mon_meta_d;
      mon_sync_q <= mon_sync_d;
      mon_prev_q <= mon_prev_d;
    end
  end

  logic [DATA_W-1:0] conv_live;
  logic [DATA_W-1:0] reg_live;
  logic [DATA_W-1:0] conv_rise;
  logic [DATA_W-1:0] reg_rise;

  always_comb begin
    conv_live = conv_word(mon_sync_q);
    reg_live = reg_word(mon_sync_q);
    conv_rise = conv_live & ~conv_word(mon_prev_q) & CONV_FLAG_BITS;
    reg_rise = reg_live & ~reg_word(mon_prev_q) & REG_UV_FLAG_BITS;
  end

  // flags, masks and thresholds
  logic [DATA_W-1:0] flag_reg_q, flag_reg_d;
  logic [DATA_W-1:0] flag_conv_q, flag_conv_d;
  logic [DATA_W-1:0] mask_reg_q, mask_reg_d;
  logic [DATA_W-1:0] mask_conv_q, mask_conv_d;
  logic [THR_W-1:0] thr1_q, thr1_d;
  logic [THR_W-1:0] thr2_q, thr2_d;

  always_comb begin
    // masking never stops a flag from setting
    flag_reg_d = flag_next(flag_reg_q, i_wr && (i_addr == PM_IRQ_STATUS_REG_UV_OFS), i_wdata,
                           reg_rise, REG_UV_FLAG_BITS);
    flag_conv_d = flag_next(flag_conv_q, i_wr && (i_addr == PM_IRQ_STATUS_CONV_OFS), i_wdata,
                            conv_rise, CONV_FLAG_BITS);
    mask_reg_d = mask_reg_q;
    mask_conv_d = mask_conv_q;
    thr1_d = thr1_q;
    thr2_d = thr2_q;
    if (i_wr) begin
      case (i_addr)
        PM_IRQ_MASK_REG_UV_OFS: mask_reg_d = i_wdata & REG_UV_FLAG_BITS;
        PM_IRQ_MASK_CONV_OFS: mask_conv_d = i_wdata & CONV_FLAG_BITS;
        CURRENT_THRESHOLD_OFS: begin
          thr1_d = i_wdata[CONV1_THR_LSB +: THR_W];
          thr2_d = i_wdata[CONV2_THR_LSB +: THR_W];
        end
        default: begin
          thr1_d = thr1_q;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flag_reg_q <= ZERO_WORD;
      flag_conv_q <= ZERO_WORD;
      mask_reg_q <= MASK_REG_UV_RST;
      mask_conv_q <= MASK_CONV_RST;
      thr1_q <= CONV1_THR_RST;
      thr2_q <= CONV2_THR_RST;
    end else begin
      flag_reg_q <= flag_reg_d;
      flag_conv_q <= flag_conv_d;
      mask_reg_q <= mask_reg_d;
      mask_conv_q <= mask_conv_d;
      thr1_q <= thr1_d;
      thr2_q <= thr2_d;
    end
  end

  // thresholds only steer the comparators; nothing here touches current limiting
  assign o_conv1_current_threshold = thr1_q;
  assign o_conv2_current_threshold = thr2_q;

  // primary interrupts, registered so they change one edge after the flags
  logic uv_irq_q, uv_irq_d;
  logic oc_irq_q, oc_irq_d;

  always_comb begin
    uv_irq_d = (|(flag_reg_q & ~mask_reg_q)) ||
               (|(flag_conv_q & ~mask_conv_q & CONV_UV_FLAG_BITS));
    oc_irq_d = |(flag_conv_q & ~mask_conv_q & CONV_OC_FLAG_BITS);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      uv_irq_q <= 1'h0;
      oc_irq_q <= 1'h0;
    end else begin
      uv_irq_q <= uv_irq_d;
      oc_irq_q <= oc_irq_d;
    end
  end

  assign o_primary_undervolt_irq = uv_irq_q;
  assign o_primary_overcurrent_irq = oc_irq_q;

  // read data stand for the one cycle after the strobe, zero otherwise
  logic [DATA_W-1:0] rdata_q, rdata_d;

  always_comb begin
    rdata_d = ZERO_WORD;
    if (i_rd) begin
      case (i_addr)
        PM_IRQ_STATUS_REG_UV_OFS: rdata_d = flag_reg_q;
        PM_IRQ_STATUS_CONV_OFS: rdata_d = flag_conv_q;
        PM_IRQ_MASK_REG_UV_OFS: rdata_d = mask_reg_q;
        PM_IRQ_MASK_CONV_OFS: rdata_d = mask_conv_q;
        CONVERTER_FAULT_STATUS_OFS: rdata_d = conv_live;
        REGULATOR_UV_STATUS_OFS: rdata_d = reg_live;
        CURRENT_THRESHOLD_OFS: begin
          rdata_d[CONV1_THR_LSB +: THR_W] = thr1_q;
          rdata_d[CONV2_THR_LSB +: THR_W] = thr2_q;
        end
        default: rdata_d = ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rdata_q <= ZERO_WORD;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;

endmodule

/* File: rfsirq_pkg.sv */
package rfsirq_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int THR_W = 4;

  // register offsets
  localparam logic [ADDR_W-1:0] PM_IRQ_STATUS_REG_UV_OFS = 16'h4013;
  localparam logic [ADDR_W-1:0] PM_IRQ_STATUS_CONV_OFS = 16'h4014;
  localparam logic [ADDR_W-1:0] PM_IRQ_MASK_REG_UV_OFS = 16'h401b;
  localparam logic [ADDR_W-1:0] PM_IRQ_MASK_CONV_OFS = 16'h401c;
  localparam logic [ADDR_W-1:0] CONVERTER_FAULT_STATUS_OFS = 16'h4054;
  localparam logic [ADDR_W-1:0] REGULATOR_UV_STATUS_OFS = 16'h4055;
  localparam logic [ADDR_W-1:0] CURRENT_THRESHOLD_OFS = 16'h40a0;

  // converter register field positions
  localparam int CONV2_OV_BIT = 13;
  localparam int CONV1_OV_BIT = 12;
  localparam int CONV2_OC_BIT = 9;
  localparam int CONV1_OC_BIT = 8;
  localparam int CONV_UV_LSB = 0;
  localparam int NUM_CONV = 4;

  // regulator register field positions
  localparam int ALWAYS_ON_UV_BIT = 15;
  localparam int REG_UV_LSB = 0;
  localparam int NUM_REG = 10;

  // threshold register field positions
  localparam int CONV1_THR_LSB = 0;
  localparam int CONV2_THR_LSB = 4;

  // implemented flag and mask bits, also the mask reset values
  localparam logic [DATA_W-1:0] REG_UV_FLAG_BITS = 16'h03ff;
  localparam logic [DATA_W-1:0] CONV_FLAG_BITS = 16'h030f;
  localparam logic [DATA_W-1:0] CONV_UV_FLAG_BITS = 16'h000f;
  localparam logic [DATA_W-1:0] CONV_OC_FLAG_BITS = 16'h0300;
  localparam logic [DATA_W-1:0] MASK_REG_UV_RST = 16'h03ff;
  localparam logic [DATA_W-1:0] MASK_CONV_RST = 16'h030f;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

  localparam logic [THR_W-1:0] CONV1_THR_RST = 4'h0;
  localparam logic [THR_W-1:0] CONV2_THR_RST = 4'h0;

  // comparator results from the analog monitors, all asynchronous levels
  typedef struct packed {
    logic always_on_undervolt;
    logic conv2_overvolt;
    logic conv1_overvolt;
    logic conv2_overcurrent;
    logic conv1_overcurrent;
    logic [NUM_CONV-1:0] conv_undervolt;
    logic [NUM_REG-1:0] regulator_undervolt;
  } rfsirq_mon_s;

  localparam rfsirq_mon_s MON_RST = '0;

endpackage

/* File: rfsirq_mon_model.sv */
`timescale 1ns/1ps
module rfsirq_mon_model
  import rfsirq_pkg::*;
(
  // levels set by the bench
  input wire rfsirq_pkg::rfsirq_mon_s i_levels,
  input wire logic [rfsirq_pkg::THR_W-1:0] i_conv1_current,
  input wire logic [rfsirq_pkg::THR_W-1:0] i_conv2_current,
  // thresholds from the device
  input wire logic [rfsirq_pkg::THR_W-1:0] i_conv1_current_threshold,
  input wire logic [rfsirq_pkg::THR_W-1:0] i_conv2_current_threshold,
  // comparator results
  output rfsirq_pkg::rfsirq_mon_s o_mon
);
  // only converters 1 and 2 carry a current comparator
  always_comb begin
    o_mon = i_levels;
    o_mon.conv1_overcurrent = i_conv1_current > i_conv1_current_threshold;
    o_mon.conv2_overcurrent = i_conv2_current > i_conv2_current_threshold;
  end
endmodule

/* File: rfsirq_checker.sv */
`timescale 1ns/1ps
module rfsirq_checker
  import rfsirq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [rfsirq_pkg::ADDR_W-1:0] i_addr,
  input wire logic [rfsirq_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [rfsirq_pkg::DATA_W-1:0] o_rdata,
  input wire rfsirq_pkg::rfsirq_mon_s i_mon,
  input wire logic [rfsirq_pkg::THR_W-1:0] o_conv1_current_threshold,
  input wire logic [rfsirq_pkg::THR_W-1:0] o_conv2_current_threshold,
  input wire logic o_primary_undervolt_irq,
  input wire logic o_primary_overcurrent_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  logic msk_q;
  logic msk_d;
  wire thr_wr = i_wr && i_addr == CURRENT_THRESHOLD_OFS;
  wire oc_any = i_mon.conv1_overcurrent | i_mon.conv2_overcurrent;
  // no irq may appear before software has touched a mask
  always_comb msk_d = msk_q | (i_wr && (i_addr == PM_IRQ_MASK_REG_UV_OFS || i_addr == PM_IRQ_MASK_CONV_OFS));
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) msk_q <= 1'h0;
    else msk_q <= msk_d;
  end
  property p_conv_sts;
    $stable(i_mon)[*5] ##0 (i_rd && i_addr == CONVERTER_FAULT_STATUS_OFS) |=> o_rdata == {2'h0,
      $past(i_mon.conv2_overvolt), $past(i_mon.conv1_overvolt), 2'h0, $past(i_mon.conv2_overcurrent),
      $past(i_mon.conv1_overcurrent), 4'h0, $past(i_mon.conv_undervolt)};
  endproperty
  a_conv_sts: assert property (p_conv_sts) else $error("converter status mismatch");
  property p_reg_sts;
    $stable(i_mon)[*5] ##0 (i_rd && i_addr == REGULATOR_UV_STATUS_OFS) |=>
      o_rdata == {$past(i_mon.always_on_undervolt), 5'h00, $past(i_mon.regulator_undervolt)};
  endproperty
  a_reg_sts: assert property (p_reg_sts) else $error("regulator status mismatch");
  property p_uv_msk; !msk_q |-> !o_primary_undervolt_irq; endproperty
  a_uv_msk: assert property (p_uv_msk) else $error("undervolt irq while masked");
  property p_oc_msk; !msk_q |-> !o_primary_overcurrent_irq; endproperty
  a_oc_msk: assert property (p_oc_msk) else $error("overcurrent irq while masked");
  property p_oc_clr;
    (!oc_any)[*5] ##0 (i_wr && i_addr == PM_IRQ_STATUS_CONV_OFS && i_wdata[9:8] == 2'h3) |->
      ##2 !o_primary_overcurrent_irq;
  endproperty
  a_oc_clr: assert property (p_oc_clr) else $error("overcurrent irq after clear");
  property p_thr_ld;
    thr_wr |=> {o_conv2_current_threshold, o_conv1_current_threshold} == $past(i_wdata[7:0]);
  endproperty
  a_thr_ld: assert property (p_thr_ld) else $error("threshold not loaded");
  property p_thr_hold; !thr_wr |=> $stable({o_conv2_current_threshold, o_conv1_current_threshold}); endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold changed");
  property p_uv_rsv; i_rd && i_addr == PM_IRQ_STATUS_REG_UV_OFS |=> o_rdata[15:10] == 6'h00; endproperty
  a_uv_rsv: assert property (p_uv_rsv) else $error("reserved flag bits set");
  c_uv_irq: cover property ($rose(o_primary_undervolt_irq));
  c_oc_irq: cover property ($rose(o_primary_overcurrent_irq));
  c_thr: cover property (thr_wr);
endmodule
bind rfsirq_top rfsirq_checker u_rfsirq_checker(.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mon(i_mon),
  .o_conv1_current_threshold(o_conv1_current_threshold), .o_conv2_current_threshold(o_conv2_current_threshold),
  .o_primary_undervolt_irq(o_primary_undervolt_irq), .o_primary_overcurrent_irq(o_primary_overcurrent_irq));

/* File: rfsirq_bench.sv */
`timescale 1ns/1ps
module rfsirq_bench;
  import rfsirq_pkg::*;
  logic i_core_clk = 1'h0, i_arst_n = 1'h0, i_wr = 1'h0, i_rd = 1'h0, uv_irq, oc_irq;
  logic [ADDR_W-1:0] i_addr = 16'h0000;
  logic [DATA_W-1:0] i_wdata = 16'h0000, o_rdata;
  logic [THR_W-1:0] thr1, thr2, cur1 = 4'h0, cur2 = 4'h0;
  rfsirq_mon_s lvl = MON_RST, mon;
  int n_fail = 0, comparisons = 0;
  rfsirq_top u_rfsirq_top(.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mon(mon), .o_conv1_current_threshold(thr1),
    .o_conv2_current_threshold(thr2), .o_primary_undervolt_irq(uv_irq), .o_primary_overcurrent_irq(oc_irq));
  rfsirq_mon_model u_rfsirq_mon_model(.i_levels(lvl), .i_conv1_current(cur1), .i_conv2_current(cur2),
    .i_conv1_current_threshold(thr1), .i_conv2_current_threshold(thr2), .o_mon(mon));
  initial begin
    forever #2 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr <= 1'h1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge i_core_clk);
    i_rd <= 1'h1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd <= 1'h0;
    #1 chk("rdata", e, o_rdata);
  endtask
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    n_fail++;
    complete_run();
  end
  initial begin
    tick(5);
    i_arst_n <= 1'h1;
    rd(PM_IRQ_MASK_REG_UV_OFS, MASK_REG_UV_RST);
    rd(PM_IRQ_MASK_CONV_OFS, MASK_CONV_RST);
    // read data stand for one cycle only, then drop back to zero
    tick(1);
    #1 chk("rdata_idle", 16'h0000, o_rdata);
    rd(PM_IRQ_STATUS_CONV_OFS, 16'h0000);
    rd(16'h4000, 16'h0000);
    wr(CURRENT_THRESHOLD_OFS, 16'h0045);
    #1 chk("thr", 16'h0045, {8'h00, thr2, thr1});
    lvl <= '1;
    cur1 <= 4'h9;
    cur2 <= 4'h3;
    tick(6);
    rd(CONVERTER_FAULT_STATUS_OFS, 16'h310f);
    rd(REGULATOR_UV_STATUS_OFS, 16'h83ff);
    rd(PM_IRQ_STATUS_CONV_OFS, 16'h010f);
    chk("irqs", 16'h0000, {14'h0000, uv_irq, oc_irq});
    wr(PM_IRQ_STATUS_REG_UV_OFS, 16'h0000);
    rd(PM_IRQ_STATUS_REG_UV_OFS, 16'h03ff);
    wr(PM_IRQ_STATUS_REG_UV_OFS, 16'h0001);
    rd(PM_IRQ_STATUS_REG_UV_OFS, 16'h03fe);
    wr(PM_IRQ_MASK_REG_UV_OFS, 16'h03fd);
    tick(3);
    #1 chk("uv_irq", 16'h0001, {15'h0000, uv_irq});
    wr(PM_IRQ_STATUS_REG_UV_OFS, 16'h0002);
    tick(3);
    #1 chk("uv_irq", 16'h0000, {15'h0000, uv_irq});
    wr(PM_IRQ_MASK_CONV_OFS, 16'h020f);
    tick(3);
    #1 chk("oc_irq", 16'h0001, {15'h0000, oc_irq});
    cur1 <= 4'h0;
    tick(6);
    wr(PM_IRQ_STATUS_CONV_OFS, 16'h0100);
    tick(3);
    #1 chk("oc_irq", 16'h0000, {15'h0000, oc_irq});
    cur2 <= 4'h9;
    tick(6);
    rd(PM_IRQ_STATUS_CONV_OFS, 16'h020f);
    chk("oc_irq", 16'h0000, {15'h0000, oc_irq});
    cur1 <= 4'h9;
    tick(6);
    #1 chk("oc_irq", 16'h0001, {15'h0000, oc_irq});
    // converter undervoltage flags also feed the undervoltage primary
    wr(PM_IRQ_MASK_CONV_OFS, 16'h020e);
    tick(3);
    #1 chk("uv_irq", 16'h0001, {15'h0000, uv_irq});
    // currents quiet long enough that clearing both flags must drop the primary
    cur1 <= 4'h0;
    cur2 <= 4'h0;
    tick(6);
    rd(CONVERTER_FAULT_STATUS_OFS, 16'h300f);
    wr(PM_IRQ_STATUS_CONV_OFS, 16'h0300);
    tick(3);
    #1 chk("oc_irq", 16'h0000, {15'h0000, oc_irq});
    rd(PM_IRQ_STATUS_CONV_OFS, 16'h000f);
    complete_run();
  end
endmodule
